// *** design/lpct_pkg.sv ***
// package: register map, field layout and types of the calibration trigger block
package lpct_pkg;
    localparam int CNT_W = 42;
    localparam logic [7:0] CTRL_IDX = 8'h6E;
    localparam logic [7:0] SWTRIG_IDX = 8'h6C;
    localparam logic [7:0] PINCFG_IDX = 8'h6B;
    localparam logic [7:0] BGCFG_IDX = 8'h60;
    localparam logic [7:0] STAT_IDX = 8'h61;
    localparam logic [7:0] CTRL_RST = 8'h88;
    localparam logic [7:0] SWTRIG_RST = 8'h01;
    localparam logic [7:0] PINCFG_RST = 8'h00;
    localparam logic [7:0] BGCFG_RST = 8'h00;
    localparam int SW_TRIG_BIT = 0;
    localparam int SRC_SEL_BIT = 0;
    localparam int BG_MODE_BIT = 0;
    localparam logic [CNT_W-1:0] CNT_ONE = 42'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 42'h000;

    // low-power control layout, bit 7 first
    typedef struct packed {
        logic [2:0] sleep_delay_code;
        logic [1:0] wake_settle_code;
        logic rsvd;
        logic trigger_wake_select;
        logic low_power_cal_enable;
    } lpct_ctrl_type;

    // captured address phase
    typedef struct packed {
        logic [31:0] addr;
        logic wr;
        logic rd;
    } lpct_aphase_type;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE = 2'b10,
        ST_CAL = 2'b11
    } lpct_state_type;

    function automatic logic [31:0] reg_addr(input logic [7:0] idx);
        reg_addr = {22'h000000, idx, 2'b00};
    endfunction

    // (2^e + 1) * unit sampling periods
    function automatic logic [CNT_W-1:0] dly(input logic [5:0] e,
                                             input logic [CNT_W-1:0] unit);
        logic [CNT_W-1:0] base;
        base = (CNT_ONE << e) + CNT_ONE;
        dly = base * unit;
    endfunction
endpackage

// *** design/lpct_top.sv ***
// low-power calibration trigger control with AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
// Function
// - a register bit acts as the calibration trigger pin for software.
// - source select 0 takes the trigger level from the software bit.
// - source select 1 uses the pin and ignores the software bit.
// - low-power control resets to 0x88: sleep 4, wake 1, all else off.
// - sleep code bits 7:5 set sleep time, only autonomous low-power.
// - sleep delay is (2^k+1)*256 periods, k by code table.
// - wake code bits 4:3 set settling time whenever low-power is on.
// - wake delay is (2^k+1)*256 periods, k 3,18,21,24.
// - trigger-wake 0: sleep ends when the sleep delay expires.
// - trigger-wake 1: core sleeps until selected trigger is low.
// - low-power enable bit 0 acts only in background calibration mode.
module lpct_top
    import lpct_pkg::*;
#(
    parameter int NUM_CORES = 3,
    parameter logic [CNT_W-1:0] DELAY_UNIT = 42'h100,
    parameter logic [7:0][5:0] SLEEP_EXP = {6'h21, 6'h1E, 6'h1B, 6'h18,
                                            6'h15, 6'h12, 6'h0F, 6'h03},
    parameter logic [3:0][5:0] WAKE_EXP = {6'h18, 6'h15, 6'h12, 6'h03}
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic calibration_trigger_pin,
    input wire logic cal_done,
    output logic cal_trigger_level,
    output logic core_sleep,
    output logic cal_run,
    output logic [1:0] core_select
);
    lpct_ctrl_type ctrl_q;
    logic [7:0] swtrig_q, pincfg_q, bgcfg_q;
    lpct_aphase_type ap_q, ap_d;
    logic [31:0] hrdata_q;
    logic pin_s1_q, pin_s2_q;
    logic trig_q;
    lpct_state_type state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [1:0] core_q, core_d;

    // bus decode
    wire aphase_ok = hsel & hready & htrans[1];
    wire unused_size = |hsize;
    wire hit_ctrl = ap_q.addr == reg_addr(CTRL_IDX);
    wire hit_sw = ap_q.addr == reg_addr(SWTRIG_IDX);
    wire hit_pin = ap_q.addr == reg_addr(PINCFG_IDX);
    wire hit_bg = ap_q.addr == reg_addr(BGCFG_IDX);
    wire hit_stat = ap_q.addr == reg_addr(STAT_IDX);
    wire [7:0] stat_val = {3'h0, core_q, state_q, trig_q};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_q :
                         hit_sw ? swtrig_q :
                         hit_pin ? pincfg_q :
                         hit_bg ? bgcfg_q :
                         hit_stat ? stat_val : 8'h00;

    assign ap_d.addr = haddr;
    assign ap_d.wr = aphase_ok & hwrite & ~unused_size | aphase_ok & hwrite;
    assign ap_d.rd = aphase_ok & ~hwrite;
    assign hreadyout = ~ap_q.rd;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= '0;
            hrdata_q <= 32'h00000000;
        end else begin
            ap_q <= ap_d;
            if (ap_q.rd) begin
                hrdata_q <= {24'h000000, rd_byte};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RST;
            swtrig_q <= SWTRIG_RST;
            pincfg_q <= PINCFG_RST;
            bgcfg_q <= BGCFG_RST;
        end else if (ap_q.wr) begin
            // full byte stored, reserved bits included
            if (hit_ctrl) begin
                ctrl_q <= hwdata[7:0];
            end else if (hit_sw) begin
                swtrig_q <= hwdata[7:0];
            end else if (hit_pin) begin
                pincfg_q <= hwdata[7:0];
            end else if (hit_bg) begin
                bgcfg_q <= hwdata[7:0];
            end
        end
    end

    // pin synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            pin_s1_q <= calibration_trigger_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // software bit stands in for the pin
    // select 0 takes the software bit
    // select 1 takes the synchronised pin
    wire src_sel = pincfg_q[SRC_SEL_BIT];
    wire trig_d = src_sel ? pin_s2_q : swtrig_q[SW_TRIG_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_q <= 1'b1;
        end else begin
            trig_q <= trig_d;
        end
    end

    wire lp_active = bgcfg_q[BG_MODE_BIT] & ctrl_q.low_power_cal_enable;
    // sleep time from the sleep code
    wire [CNT_W-1:0] sleep_cnt = dly(SLEEP_EXP[ctrl_q.sleep_delay_code], DELAY_UNIT);
    // wake time from the wake code
    wire [CNT_W-1:0] wake_cnt = dly(WAKE_EXP[ctrl_q.wake_settle_code], DELAY_UNIT);
    wire cnt_end = cnt_q <= CNT_ONE;
    wire last_core = core_q == 2'(NUM_CORES - 1);

    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q > CNT_ZERO) ? cnt_q - CNT_ONE : CNT_ZERO;
        core_d = core_q;
        if (!lp_active) begin
            state_d = ST_OFF;
            cnt_d = CNT_ZERO;
        end else begin
            case (state_q)
                ST_OFF: begin
                    state_d = ST_SLEEP;
                    cnt_d = sleep_cnt;
                end
                ST_SLEEP: begin
                    if (ctrl_q.trigger_wake_select) begin
                        cnt_d = CNT_ZERO;
                        if (!trig_q) begin
                            state_d = ST_WAKE;
                            cnt_d = wake_cnt;
                        end
                    end else if (cnt_end) begin
                        state_d = ST_WAKE;
                        cnt_d = wake_cnt;
                    end
                end
                ST_WAKE: begin
                    if (cnt_end) begin
                        state_d = ST_CAL;
                    end
                end
                default: begin
                    if (cal_done) begin
                        state_d = ST_SLEEP;
                        cnt_d = sleep_cnt;
                        core_d = last_core ? 2'h0 : core_q + 2'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_OFF;
            cnt_q <= CNT_ZERO;
            core_q <= 2'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            core_q <= core_d;
        end
    end

    assign cal_trigger_level = trig_q;
    assign core_sleep = state_q == ST_SLEEP;
    assign cal_run = state_q == ST_CAL;
    assign core_select = core_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_sw_source: assert property (
        !src_sel |=> trig_q == $past(swtrig_q[SW_TRIG_BIT]))
        else $error("trigger not from software bit");
    a_pin_source: assert property (
        src_sel |=> trig_q == $past(pin_s2_q))
        else $error("trigger not from pin");
    a_sleep_expiry: assert property (
        state_q == ST_SLEEP && lp_active && !ctrl_q.trigger_wake_select && cnt_end
        |=> state_q == ST_WAKE)
        else $error("sleep did not end on expiry");
    a_trig_hold: assert property (
        state_q == ST_SLEEP && lp_active && ctrl_q.trigger_wake_select && trig_q
        |=> state_q == ST_SLEEP)
        else $error("woke while trigger high");
    a_trig_wake: assert property (
        state_q == ST_SLEEP && lp_active && ctrl_q.trigger_wake_select && !trig_q
        |=> state_q == ST_WAKE)
        else $error("no wake on low trigger");
    a_wake_load: assert property (
        state_q == ST_SLEEP && state_d == ST_WAKE
        |=> cnt_q == $past(wake_cnt)
        ##1 (!$past(lp_active) || cnt_q == $past(wake_cnt, 2) - CNT_ONE))
        else $error("wake delay wrong");
    a_sleep_load: assert property (
        state_q != ST_SLEEP && state_d == ST_SLEEP |=> cnt_q == $past(sleep_cnt))
        else $error("sleep delay wrong");
    a_off_clear: assert property (
        !lp_active |=> state_q == ST_OFF && cnt_q == CNT_ZERO)
        else $error("disable did not clear");
    a_ctrl_write: assert property (
        ap_q.wr && hit_ctrl |=> ctrl_q == $past(hwdata[7:0]))
        else $error("control write lost");
    a_read_wait: assert property (
        ap_q.rd |-> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");

    a_soft_write: assert property (
        ap_q.wr && hit_sw |=> swtrig_q == $past(hwdata[7:0]))
        else $error("software trigger write lost");
    a_pin_write: assert property (
        ap_q.wr && hit_pin |=> pincfg_q == $past(hwdata[7:0]))
        else $error("source select write lost");
    a_bg_write: assert property (
        ap_q.wr && hit_bg |=> bgcfg_q == $past(hwdata[7:0]))
        else $error("background mode write lost");
    a_ctrl_readback: assert property (
        ap_q.rd && hit_ctrl |=> hrdata == {24'h000000, $past(ctrl_q)})
        else $error("control readback wrong");

    a_pin_ignored: assert property (
        !src_sel && $stable(src_sel) && $stable(swtrig_q[SW_TRIG_BIT])
        |=> $stable(trig_q))
        else $error("pin leaked into software trigger");
    a_trig_nocount: assert property (
        state_q == ST_SLEEP && lp_active && ctrl_q.trigger_wake_select && trig_q
        |=> cnt_q == CNT_ZERO)
        else $error("sleep delay used in trigger mode");

    a_enable_start: assert property (
        state_q == ST_OFF && lp_active |=> state_q == ST_SLEEP)
        else $error("enable did not start sleep");
    a_bg_gate: assert property (
        !bgcfg_q[BG_MODE_BIT] |=> state_q == ST_OFF)
        else $error("sequence ran without background mode");
    a_sleep_count: assert property (
        state_q == ST_SLEEP && lp_active && !ctrl_q.trigger_wake_select && !cnt_end
        |=> state_q == ST_SLEEP && cnt_q == $past(cnt_q) - CNT_ONE)
        else $error("sleep count wrong");

    a_wake_expiry: assert property (
        state_q == ST_WAKE && lp_active && cnt_end
        |=> state_q == ST_CAL)
        else $error("settling did not end");
    a_wake_hold: assert property (
        state_q == ST_WAKE && lp_active && !cnt_end
        |=> state_q == ST_WAKE)
        else $error("settling ended early");
    a_wake_count: assert property (
        state_q == ST_WAKE && lp_active && !cnt_end
        |=> cnt_q == $past(cnt_q) - CNT_ONE)
        else $error("settling count wrong");

    c_auto_wake: cover property (state_q == ST_SLEEP ##1 state_q == ST_WAKE);
    c_cal_done: cover property (state_q == ST_CAL ##1 state_q == ST_SLEEP);
    c_trig_wake: cover property (ctrl_q.trigger_wake_select && state_q == ST_WAKE);
    c_pin_trigger: cover property (src_sel && !trig_q);
    c_disable_off: cover property (state_q == ST_SLEEP ##1 state_q == ST_OFF);
endmodule
`default_nettype wire

// *** tb/lpct_trig_model.sv ***
// behavioural system logic driving the calibration trigger pin
`timescale 1ns/1ns
`default_nettype none
module lpct_trig_model (
    input wire logic hclk,
    input wire logic drive_en,
    input wire logic level,
    output logic calibration_trigger_pin
);
    initial calibration_trigger_pin = 1'b1;
    // released pin has no pull, so it toggles
    always @(posedge hclk) begin
        calibration_trigger_pin <= drive_en ? level : ~calibration_trigger_pin;
    end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the calibration trigger block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import lpct_pkg::*;
    localparam logic [7:0][5:0] SEXP = {6'h03, 6'h02, 6'h03, 6'h02, 6'h02, 6'h03, 6'h02, 6'h03};
    localparam logic [3:0][5:0] WEXP = {6'h03, 6'h02, 6'h03, 6'h02};
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cal_done = 0, drv_en = 0, drv_lvl = 1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rnd = 32'hA95E, exp_q[$];
    logic rd_ph = 0;
    lpct_ctrl_type c;
    string nm_q[$];
    int err_count = 0, n_compared = 0, cyc = 0, ns, nw, cs0;
    wire logic hreadyout, hresp, pin, trig, sleep, run;
    wire logic [31:0] hrdata;
    wire logic [1:0] csel;
    always #20 hclk = ~hclk;
    lpct_top #(.DELAY_UNIT(42'h001), .SLEEP_EXP(SEXP), .WAKE_EXP(WEXP)) DUT (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .calibration_trigger_pin(pin), .cal_done(cal_done),
        .cal_trigger_level(trig), .core_sleep(sleep), .cal_run(run), .core_select(csel));
    lpct_trig_model PTNR (.hclk(hclk), .drive_en(drv_en), .level(drv_lvl),
        .calibration_trigger_pin(pin));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        if (!hclk) @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h000000, idx, 2'b00};
        hwrite <= w;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
        exp_q.push_back({24'h000000, e});
        nm_q.push_back(nm);
        bus(1'b0, idx, 8'h00);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask
    task automatic measure;
        ns = 0;
        nw = 0;
        while (!sleep) @(negedge hclk);
        while (sleep) begin
            ns++;
            @(negedge hclk);
        end
        while (!run) begin
            nw++;
            @(negedge hclk);
        end
    endtask
    // read data checked against the oldest note
    always @(posedge hclk) begin
        if (rd_ph && hreadyout && exp_q.size() > 0) begin
            chk(nm_q.pop_front(), exp_q.pop_front(), hrdata);
            chk("bus response", 32'h0, {31'h0, hresp});
        end
        if (hreadyout)
            rd_ph <= hsel && htrans[1] && !hwrite;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00, "unmapped");
        rd(CTRL_IDX, 8'h88, "control reset");
        rd(SWTRIG_IDX, 8'h01, "soft trigger reset");
        rd(PINCFG_IDX, 8'h00, "source select reset");
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            wr(CTRL_IDX, {rnd[7:1], 1'b0});
            rd(CTRL_IDX, {rnd[7:1], 1'b0}, "control rw");
            wr(SWTRIG_IDX, rnd[15:8]);
            rd(SWTRIG_IDX, rnd[15:8], "soft trigger rw");
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            drv_en <= i[1];
            drv_lvl <= ~i[0];
            wr(PINCFG_IDX, {7'h00, i[1]});
            wr(SWTRIG_IDX, {7'h00, i[0]});
            settle(4);
            chk("trigger level", {31'h0, i[1] ^ i[0]}, {31'h0, trig});
        end
        drv_en <= 1'b0;
        wr(PINCFG_IDX, 8'h00);
        wr(SWTRIG_IDX, 8'h01);
        wr(CTRL_IDX, 8'h89);
        settle(10);
        chk("sleep without background", 32'h0, {31'h0, sleep});
        wr(CTRL_IDX, 8'h88);
        wr(BGCFG_IDX, 8'h01);
        $display("test trigger source done");
        for (int r = 0; r < 8; r++) begin
            c = '{r[2:0], r[1:0], 1'b0, 1'b0, 1'b1};
            wr(CTRL_IDX, c);
            measure();
            cs0 = csel;
            chk("sleep cycles", (32'h1 << SEXP[r]) + 32'h1, 32'(ns));
            chk("wake cycles", (32'h1 << WEXP[r % 4]) + 32'h1, 32'(nw));
            @(posedge hclk);
            cal_done <= 1'b1;
            @(posedge hclk);
            cal_done <= 1'b0;
            settle(0);
            chk("next core", 32'((cs0 + 1) % 3), {30'h0, csel});
            chk("sleep again", 32'h1, {31'h0, sleep});
            wr(CTRL_IDX, 8'h88);
            settle(1);
            chk("off when disabled", 32'h0, {31'h0, sleep | run});
        end
        $display("test autonomous done");
        wr(CTRL_IDX, 8'h0B);
        settle(40);
        chk("held asleep", 32'h1, {31'h0, sleep});
        rd(STAT_IDX, 8'h13, "status asleep");
        wr(SWTRIG_IDX, 8'h00);
        settle(3);
        chk("woken by trigger", 32'h0, {31'h0, sleep});
        $display("test trigger wake done");
        complete_run();
    end
endmodule
`default_nettype wire
